// ---- lpmc_cfg.svh ----
// constants for the low-power mode controller
// Operation
// - executing the full-stop instruction turns the oscillator off and halts every timer.
// - entering full stop clears the interrupt mask bit and leaves every other state alone.
// - in full stop every input/output line holds the level it had before entry.
// - full stop ends only on an external, enabled keyboard, enabled low-voltage or reset event.
// - with the full-stop mask option set, the full-stop instruction acts as a no-operation.
// - after a full-stop wake-up a fixed 4064-cycle delay passes before execution resumes.
// - the wait instruction halts the processor while both timers and the converter keep running.
// - wait ends on an enabled external, keyboard, low-voltage, core timer or 16-bit timer event.
// - entering wait clears the interrupt mask bit and leaves every other state alone.
// - an enabled core timer interrupt ends the wait state, giving periodic wake-ups.
// - the external interrupt pin is falling-edge or falling-edge-and-level sensitive by option.
// - the block clock is the oscillator divided by two and all counts use it.
`ifndef LPMC_CFG_SVH
`define LPMC_CFG_SVH

// recovery delay in bus clock cycles, and its counter width
`define LPMC_CNT_W           12
`define LPMC_RECOVERY_CYCLES 12'h0fe0
`define LPMC_CNT_ZERO        12'h0000
`define LPMC_CNT_ONE         12'h0001

// bit positions of the wake source vector
`define LPMC_WK_W   5
`define LPMC_WK_EXT 0
`define LPMC_WK_KBD 1
`define LPMC_WK_LVI 2
`define LPMC_WK_CTM 3
`define LPMC_WK_PTM 4
`define LPMC_WK_NONE 5'h00

`endif

// ---- lpmc_pkg.sv ----
// types shared by the low-power mode controller
`default_nettype none
package lpmc_pkg;
	// one-hot power states
	typedef enum logic [3:0] {
		LPMC_RUN     = 4'h1,
		LPMC_STOP    = 4'h2,
		LPMC_RECOVER = 4'h4,
		LPMC_WAIT    = 4'h8
	} lpmc_state_type;
endpackage : lpmc_pkg
`default_nettype wire

// ---- lpmc_rec_if.sv ----
// handshake between the state machine and the recovery counter
`timescale 1ns/1ps
`default_nettype none
interface lpmc_rec_if;
	logic start;
	logic busy;
	logic done;
	modport ctrl  (output start, input busy, input done);
	modport timer (input start, output busy, output done);
endinterface : lpmc_rec_if
`default_nettype wire

// ---- lpmc_recovery.sv ----
// recovery delay counter used after leaving full stop
`timescale 1ns/1ps
`default_nettype none
`include "lpmc_cfg.svh"
module lpmc_recovery #(
	parameter logic [`LPMC_CNT_W-1:0] RECOVERY_CYCLES = `LPMC_RECOVERY_CYCLES
) (
	// clock and synchronised reset
	input  wire logic    core_clk,
	input  wire logic    rst_n,
	// handshake
	lpmc_rec_if.timer    rec
);
	logic [`LPMC_CNT_W-1:0] remain;
	logic [`LPMC_CNT_W-1:0] len;
	logic                   busy;
	wire                    last = busy && (remain == `LPMC_CNT_ONE);

	assign rec.busy = busy;
	assign rec.done = last;

	// load on start, then count down one per bus clock
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy   <= 1'b0;
			remain <= `LPMC_CNT_ZERO;
		end else if (rec.start) begin
			busy   <= 1'b1;
			remain <= RECOVERY_CYCLES;
		end else if (busy) begin
			busy   <= !last;
			remain <= remain - `LPMC_CNT_ONE;
		end
	end

	// helper: busy cycles seen so far, for the length check
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			len <= `LPMC_CNT_ZERO;
		end else begin
			len <= busy ? len + `LPMC_CNT_ONE : `LPMC_CNT_ZERO;
		end
	end

	property p_rec_len;
		@(posedge core_clk) disable iff (!rst_n)
		rec.done |-> (len == RECOVERY_CYCLES - `LPMC_CNT_ONE);
	endproperty
	a_rec_len: assert property (p_rec_len) else $error("recovery delay length wrong");
endmodule : lpmc_recovery
`default_nettype wire

// ---- lpmc_top.sv ----
// low-power mode controller: full stop, wait, wake-up and recovery
`timescale 1ns/1ps
`default_nettype none
`include "lpmc_cfg.svh"
module lpmc_top #(
	parameter logic [`LPMC_CNT_W-1:0] RECOVERY_CYCLES = `LPMC_RECOVERY_CYCLES
) (
	// clock (bus clock, oscillator divided by two) and reset
	input  wire logic                  core_clk,
	input  wire logic                  resetn,
	// processor core
	input  wire logic                  stop_exec,
	input  wire logic                  wait_exec,
	input  wire logic                  ext_ack,
	output logic                       imask_clear,
	output logic                       stop_nop,
	output logic                       cpu_halt,
	// mask option and option register
	input  wire logic                  stop_disable,
	input  wire logic                  irq_edge_only,
	// wake-up sources and enables
	input  wire logic                  irq_n,
	input  wire logic                  kbd_irq,
	input  wire logic                  kbd_en,
	input  wire logic                  lvi_n,
	input  wire logic                  lvi_en,
	input  wire logic                  ctimer_irq,
	input  wire logic                  ctimer_en,
	input  wire logic                  ptimer_irq,
	input  wire logic                  ptimer_en,
	// subsystem run controls
	output logic                       osc_run,
	output logic                       ctimer_run,
	output logic                       ptimer_run,
	output logic                       adc_run,
	output logic                       watchdog_run,
	output logic                       io_hold,
	// status
	output logic                       ext_pending,
	output logic                       recovering,
	output logic [`LPMC_WK_W-1:0]      wake_src,
	output lpmc_pkg::lpmc_state_type   mode
);
	// reset release through two flops; assertion stays asynchronous
	logic rst_meta;
	logic rst_n;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	lpmc_pkg::lpmc_state_type state;
	lpmc_pkg::lpmc_state_type next_state;
	logic                     irq_prev;
	logic                     ext_pend;

	lpmc_rec_if rec ();

	lpmc_recovery #(
		.RECOVERY_CYCLES (RECOVERY_CYCLES)
	) u_recovery (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.rec      (rec.timer)
	);

	// external pin: falling edge always counts, low level only in level mode
	wire irq_fall = irq_prev && !irq_n;
	wire ext_req  = ext_pend || (!irq_edge_only && !irq_n);

	// enabled wake-up requests; the low-voltage line is driven low from outside
	wire kbd_req = kbd_irq && kbd_en;
	wire lvi_req = !lvi_n && lvi_en;
	wire ctm_req = ctimer_irq && ctimer_en;
	wire ptm_req = ptimer_irq && ptimer_en;

	// timers cannot end full stop because their clocks are gone
	wire stop_wake = ext_req || kbd_req || lvi_req;
	wire wait_wake = stop_wake || ctm_req || ptm_req;

	// entry decode; a masked-off full stop falls through as a no-operation
	// a wait in the same cycle as any stop is dropped, so a no-op never sleeps
	wire in_run     = (state == lpmc_pkg::LPMC_RUN);
	wire stop_taken = in_run && stop_exec && !stop_disable;
	wire stop_skip  = in_run && stop_exec && stop_disable;
	wire wait_taken = in_run && wait_exec && !stop_exec;
	wire enter_low  = stop_taken || wait_taken;

	// a wake from full stop restarts the oscillator and the delay count
	wire stop_exit = (state == lpmc_pkg::LPMC_STOP) && stop_wake;
	wire wait_exit = (state == lpmc_pkg::LPMC_WAIT) && wait_wake;
	assign rec.start = stop_exit;

	wire [`LPMC_WK_W-1:0] wake_vec = {ptm_req, ctm_req, lvi_req, kbd_req, ext_req};
	wire [`LPMC_WK_W-1:0] stop_vec = wake_vec & {1'b0, 1'b0, 1'b1, 1'b1, 1'b1};

	// next state decode
	always_comb begin
		next_state = state;
		unique case (state)
			lpmc_pkg::LPMC_RUN: begin
				if (stop_taken) begin
					next_state = lpmc_pkg::LPMC_STOP;
				end else if (wait_taken) begin
					next_state = lpmc_pkg::LPMC_WAIT;
				end
			end
			lpmc_pkg::LPMC_STOP: begin
				if (stop_wake) begin
					next_state = lpmc_pkg::LPMC_RECOVER;
				end
			end
			lpmc_pkg::LPMC_RECOVER: begin
				if (rec.done) begin
					next_state = lpmc_pkg::LPMC_RUN;
				end
			end
			lpmc_pkg::LPMC_WAIT: begin
				if (wait_wake) begin
					next_state = lpmc_pkg::LPMC_RUN;
				end
			end
			default: begin
				next_state = lpmc_pkg::LPMC_RUN;
			end
		endcase
	end

	// run controls decoded from the next state so they change with it
	wire n_run  = (next_state == lpmc_pkg::LPMC_RUN);
	wire n_wait = (next_state == lpmc_pkg::LPMC_WAIT);
	wire n_stop = (next_state == lpmc_pkg::LPMC_STOP);
	wire n_live = n_run || n_wait;

	// state and external edge tracking
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state    <= lpmc_pkg::LPMC_RUN; // reset also abandons recovery
			irq_prev <= 1'b1;
		end else begin
			state    <= next_state;
			irq_prev <= irq_n;
		end
	end

	// pending edge: a new edge wins over the acknowledge in the same cycle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_pend <= 1'b0;
		end else begin
			ext_pend <= irq_fall || (ext_pend && !ext_ack);
		end
	end

	// core handshakes: mask clear on entry to either low-power state
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			imask_clear <= 1'b0;
			stop_nop    <= 1'b0;
		end else begin
			imask_clear <= enter_low;
			stop_nop    <= stop_skip;
		end
	end

	// subsystem controls; other registers and memory are simply left untouched
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			osc_run      <= 1'b1;
			cpu_halt     <= 1'b0;
			ctimer_run   <= 1'b1;
			ptimer_run   <= 1'b1;
			adc_run      <= 1'b1;
			watchdog_run <= 1'b1;
			io_hold      <= 1'b0;
		end else begin
			osc_run      <= !n_stop;
			cpu_halt     <= !n_run;
			ctimer_run   <= n_live;
			ptimer_run   <= n_live;
			adc_run      <= n_live;
			watchdog_run <= n_live;
			io_hold      <= !n_run;
		end
	end

	// status: the source that ended the last low-power state
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wake_src <= `LPMC_WK_NONE;
		end else if (stop_exit) begin
			wake_src <= stop_vec;
		end else if (wait_exit) begin
			wake_src <= wake_vec;
		end
	end

	assign ext_pending = ext_pend;
	assign recovering  = rec.busy;
	assign mode        = state;

	// checks
	property p_stop_osc;
		@(posedge core_clk) disable iff (!rst_n)
		(state == lpmc_pkg::LPMC_STOP) |-> (!osc_run && !ctimer_run && !watchdog_run);
	endproperty
	a_stop_osc: assert property (p_stop_osc) else $error("clocks running in full stop");

	property p_stop_imask;
		@(posedge core_clk) disable iff (!rst_n)
		stop_taken |=> imask_clear && (state == lpmc_pkg::LPMC_STOP) ##1 !imask_clear;
	endproperty
	a_stop_imask: assert property (p_stop_imask) else $error("mask not cleared on stop");

	property p_io_hold;
		@(posedge core_clk) disable iff (!rst_n)
		(state != lpmc_pkg::LPMC_RUN) |-> io_hold;
	endproperty
	a_io_hold: assert property (p_io_hold) else $error("lines released in low power");

	property p_stop_stay;
		@(posedge core_clk) disable iff (!rst_n)
		(state == lpmc_pkg::LPMC_STOP) && !stop_wake |=> (state == lpmc_pkg::LPMC_STOP);
	endproperty
	a_stop_stay: assert property (p_stop_stay) else $error("stop left without wake");

	property p_stop_nop;
		@(posedge core_clk) disable iff (!rst_n)
		stop_skip |=> (state == lpmc_pkg::LPMC_RUN) && stop_nop && !imask_clear;
	endproperty
	a_stop_nop: assert property (p_stop_nop) else $error("masked stop entered");

	property p_recover;
		@(posedge core_clk) disable iff (!rst_n)
		stop_exit |=> (state == lpmc_pkg::LPMC_RECOVER) && cpu_halt && recovering;
	endproperty
	a_recover: assert property (p_recover) else $error("no recovery after stop");

	property p_wait_run;
		@(posedge core_clk) disable iff (!rst_n)
		(state == lpmc_pkg::LPMC_WAIT) |-> cpu_halt && ctimer_run && ptimer_run && adc_run;
	endproperty
	a_wait_run: assert property (p_wait_run) else $error("wait controls wrong");

	property p_wait_exit;
		@(posedge core_clk) disable iff (!rst_n)
		wait_exit |=> (state == lpmc_pkg::LPMC_RUN) && !cpu_halt && (wake_src != `LPMC_WK_NONE);
	endproperty
	a_wait_exit: assert property (p_wait_exit) else $error("wait not ended");

	property p_wait_imask;
		@(posedge core_clk) disable iff (!rst_n)
		wait_taken |=> imask_clear ##1 !imask_clear;
	endproperty
	a_wait_imask: assert property (p_wait_imask) else $error("mask not cleared on wait");

	property p_ctm_wake;
		@(posedge core_clk) disable iff (!rst_n)
		(state == lpmc_pkg::LPMC_WAIT) && ctimer_irq && ctimer_en
			|=> (state == lpmc_pkg::LPMC_RUN) && wake_src[`LPMC_WK_CTM];
	endproperty
	a_ctm_wake: assert property (p_ctm_wake) else $error("core timer did not wake");

	property p_edge;
		@(posedge core_clk) disable iff (!rst_n)
		irq_fall |=> ext_pending;
	endproperty
	a_edge: assert property (p_edge) else $error("falling edge lost");
endmodule : lpmc_top
`default_nettype wire

// ---- lpmc_core_model.sv ----
// behavioural processor core and wake-up sources facing the controller
`timescale 1ns/1ps
`default_nettype none
module lpmc_core_model (
	// clock
	input  wire logic       core_clk,
	// instruction and acknowledge pulses
	output var logic        stop_exec,
	output var logic        wait_exec,
	output var logic        ext_ack,
	// wake-up pins; src is pt_en, pt, ct_en, ct, lvi_en, kbd_en, kbd
	output var logic        irq_n,
	output var logic        lvi_n,
	output var logic [6:0]  src
);
	// idle values, so nothing wakes the controller out of reset
	initial begin
		{stop_exec, wait_exec, ext_ack} = 3'h0;
		{irq_n, lvi_n} = 2'h3;
		src = 7'h00;
	end
	// one-cycle pulse, launched after a falling edge so the rising edge sees it settled
	task automatic pulse(input logic s, input logic w, input logic a);
		@(negedge core_clk);
		{stop_exec, wait_exec, ext_ack} = {s, w, a};
		@(negedge core_clk);
		{stop_exec, wait_exec, ext_ack} = 3'h0;
	endtask : pulse
	// all sources move together
	task automatic drive(input logic i, input logic l, input logic [6:0] s);
		@(negedge core_clk);
		irq_n = i;
		lvi_n = l; // outside logic pulls this low on a supply drop
		src = s;
	endtask : drive
endmodule : lpmc_core_model
`default_nettype wire

// ---- low_power_mode_control_tb.sv ----
// self-checking bench for the low-power mode controller
`timescale 1ns/1ps
`default_nettype none
module low_power_mode_control_tb;
	// short recovery count keeps the run brief
	localparam logic [11:0] RC = 12'h0008;
	localparam logic [3:0] RU = lpmc_pkg::LPMC_RUN;
	localparam logic [3:0] ST = lpmc_pkg::LPMC_STOP;
	localparam logic [3:0] RE = lpmc_pkg::LPMC_RECOVER;
	localparam logic [3:0] WT = lpmc_pkg::LPMC_WAIT;
	logic        core_clk, resetn, stop_disable, irq_edge_only, mon_en;
	logic        stop_exec, wait_exec, ext_ack, irq_n, lvi_n;
	logic [6:0]  src;
	logic        imask_clear, stop_nop, cpu_halt, osc_run, ctimer_run, ptimer_run;
	logic        adc_run, watchdog_run, io_hold, ext_pending, recovering;
	logic [4:0]  wake_src;
	logic [3:0]  prev;
	logic [37:0] notes[$];
	int          n_errors, n_checks, dwell;
	lpmc_pkg::lpmc_state_type mode;

	lpmc_core_model core_u (.core_clk(core_clk), .stop_exec(stop_exec),
		.wait_exec(wait_exec), .ext_ack(ext_ack), .irq_n(irq_n), .lvi_n(lvi_n), .src(src));
	lpmc_top #(.RECOVERY_CYCLES(RC)) dut_u (.core_clk(core_clk), .resetn(resetn),
		.stop_exec(stop_exec), .wait_exec(wait_exec), .ext_ack(ext_ack),
		.imask_clear(imask_clear), .stop_nop(stop_nop), .cpu_halt(cpu_halt),
		.stop_disable(stop_disable), .irq_edge_only(irq_edge_only), .irq_n(irq_n),
		.kbd_irq(src[0]), .kbd_en(src[1]), .lvi_n(lvi_n), .lvi_en(src[2]),
		.ctimer_irq(src[3]), .ctimer_en(src[4]), .ptimer_irq(src[5]), .ptimer_en(src[6]),
		.osc_run(osc_run), .ctimer_run(ctimer_run), .ptimer_run(ptimer_run),
		.adc_run(adc_run), .watchdog_run(watchdog_run), .io_hold(io_hold),
		.ext_pending(ext_pending), .recovering(recovering), .wake_src(wake_src), .mode(mode));

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	// a hang past the cycle budget ends the run as a failure
	initial begin
		#2000000;
		n_errors++;
		print_verdict();
	end

	task automatic print_verdict();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask : cyc
	// outputs per state: mode, osc, ct, pt, adc, wd, halt, hold, rec, imask, nop, wake
	function automatic logic [18:0] look(input logic [3:0] m, input logic [4:0] w);
		logic r;
		logic a;
		r = (m == RU);
		a = r | (m == WT);
		look = {m, m != ST, a, a, a, a, !r, !r, m == RE, m == ST | m == WT, 1'b0, w};
	endfunction : look
	task automatic note(input logic [3:0] m, input logic [4:0] w, input logic [18:0] k);
		notes.push_back({k, look(m, w)});
	endtask : note
	// sleep, try a refused instruction, then wake; no expected source means a kbd rescue
	task automatic sleep(input logic stp, input logic i, input logic l, input logic [6:0] s,
			input logic [4:0] w);
		note(stp ? ST : WT, 5'h00, 19'h7_ffe0);
		core_u.pulse(stp, !stp, 1'b0);
		core_u.pulse(1'b1, 1'b1, 1'b0);
		if (w == 5'h00) begin
			core_u.drive(i, l, s);
			cyc(4);
			{i, l, s, w} = {2'b11, 7'h03, 5'h02};
		end
		// leaving stop masks adc and timer wake bits, whose reading is open
		note(stp ? RE : RU, w, stp ? 19'h7_f7e7 : 19'h7_ffff);
		if (stp)
			note(RU, 5'h00, 19'h7_ffe0);
		core_u.drive(i, l, s);
		cyc(stp ? RC + 3 : 3);
		core_u.drive(1'b1, 1'b1, 7'h00);
		core_u.pulse(1'b0, 1'b0, 1'b1);
		cyc(2);
	endtask : sleep

	// each state change or no-op pulse is a result matched against the oldest note
	always @(negedge core_clk) begin
		logic [37:0] n;
		logic [18:0] got;
		got = {mode, osc_run, ctimer_run, ptimer_run, adc_run, watchdog_run, cpu_halt,
			io_hold, recovering, imask_clear, stop_nop, wake_src};
		if (mon_en && (mode !== prev || stop_nop !== 1'b0)) begin
			if (prev === RE && resetn === 1'b1) begin
				n_checks++;
				if (dwell != RC) begin
					n_errors++;
					$display("Error at %0t: recovery %h expected %h", $time, dwell, RC);
				end
			end
			// an unexpected result meets an impossible note
			n = (notes.size() > 0) ? notes.pop_front() : {19'h7_ffff, ~got};
			n_checks++;
			if ((got & n[37:19]) !== (n[18:0] & n[37:19])) begin
				n_errors++;
				$display("Error at %0t: got %h expected %h", $time, got & n[37:19],
					n[18:0] & n[37:19]);
			end
			dwell = 0;
		end
		dwell++;
		prev = mode;
	end

	initial begin
		logic [6:0] s;
		logic       l;
		logic [4:0] w;
		{resetn, stop_disable, irq_edge_only, mon_en} = 4'h2;
		{n_errors, n_checks, dwell} = {32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
		prev = RU;
		void'($urandom(32'hf034_2769));
		cyc(10);
		resetn = 1'b1;
		cyc(4);
		mon_en = 1'b1;
		sleep(1'b1, 1'b0, 1'b1, 7'h00, 5'h01);
		sleep(1'b1, 1'b1, 1'b0, 7'h04, 5'h04);
		sleep(1'b1, 1'b1, 1'b0, 7'h79, 5'h00);
		sleep(1'b0, 1'b1, 1'b1, 7'h18, 5'h08);
		sleep(1'b0, 1'b0, 1'b1, 7'h61, 5'h10);
		$display("test done: directed wake-ups");
		// random sources and enables in both states
		for (int k = 0; k < 16; k++) begin
			s = 7'($urandom());
			l = 1'($urandom());
			w = {s[6] & s[5], s[4] & s[3], !l & s[2], s[1] & s[0], 1'b0};
			sleep(k[0], 1'b1, l, s, k[0] ? w & 5'h07 : w);
		end
		$display("test done: random wake-ups");
		// with the option set stop is a no-op and the same-cycle wait is dropped
		stop_disable = 1'b1;
		notes.push_back({19'h7_ffe0, look(RU, 5'h00) | 19'h0_0020});
		core_u.pulse(1'b1, 1'b1, 1'b0);
		cyc(3);
		stop_disable = 1'b0;
		$display("test done: disabled stop");
		// an edge-only pin held low cannot wake; level sensing then does
		core_u.drive(1'b0, 1'b1, 7'h00);
		cyc(2);
		n_checks++;
		if (ext_pending !== 1'b1) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, ext_pending, 1'b1);
		end
		core_u.pulse(1'b0, 1'b0, 1'b1);
		n_checks++;
		if (ext_pending !== 1'b0) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, ext_pending, 1'b0);
		end
		note(WT, 5'h00, 19'h7_ffe0);
		core_u.pulse(1'b0, 1'b1, 1'b0);
		cyc(4);
		note(RU, 5'h01, 19'h7_ffff);
		irq_edge_only = 1'b0;
		cyc(3);
		core_u.drive(1'b1, 1'b1, 7'h00);
		core_u.pulse(1'b0, 1'b0, 1'b1);
		irq_edge_only = 1'b1;
		$display("test done: pin sensing");
		// reset in mid-recovery abandons the count
		note(ST, 5'h00, 19'h7_ffe0);
		core_u.pulse(1'b1, 1'b0, 1'b0);
		note(RE, 5'h02, 19'h7_f7e7);
		core_u.drive(1'b1, 1'b1, 7'h03);
		cyc(3);
		note(RU, 5'h00, 19'h7_ffe0);
		cyc(1);
		resetn = 1'b0;
		cyc(2);
		resetn = 1'b1;
		core_u.drive(1'b1, 1'b1, 7'h00);
		cyc(5);
		$display("test done: reset in recovery");
		n_checks++;
		if (notes.size() != 0) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, notes.size(), 0);
		end
		print_verdict();
	end
endmodule : low_power_mode_control_tb
`default_nettype wire
